// [core/downstream_addr_remap_regs.sv]
/*
 * Downstream non-transparent address remap register bank, a classic
 * Wishbone slave on the bridge clock, with its fields driven out to the
 * remapping datapath. Assumes a master that holds each request until ack.
 */
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ns

// What this block does
// - The non-prefetchable control word keeps a writable lower base in bits 31:20, zero at reset.
// - Bits 12:8 of that word are a writable count of upper I/O address bits to drop, zero at reset.
// - Bit 3 of that word is a writable enable for non-prefetchable remapping, zero at reset.
// - The prefetchable control word keeps a writable lower base in bits 31:20, zero at reset.
// - Bit 3 of that word is a writable enable for prefetchable remapping, zero at reset.
// - Both secondary upper base words are fully writable over 32 bits and reset to zero.
// - The primary non-prefetchable upper base word is fully writable and resets to zero.
// - The primary non-prefetchable upper limit word is fully writable and resets to zero.
module downstream_addr_remap_regs
	import remap_regs_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Non-prefetchable window
	output logic [11:0] sec_nonpref_lower_base,
	output logic [4:0] io_discard_bits,
	output logic nonpref_remap_enable,
	output logic [31:0] sec_nonpref_upper_base,
	// Prefetchable window
	output logic [11:0] sec_pref_lower_base,
	output logic pref_remap_enable,
	output logic [31:0] sec_pref_upper_base,
	// Primary non-prefetchable window
	output logic [31:0] pri_nonpref_upper_base,
	output logic [31:0] pri_nonpref_upper_limit
);

	// ************************************************************
	// State
	// ************************************************************
	typedef struct packed {
		logic [NREG-1:0][31:0] regs;
		logic ack;
		logic [31:0] rdata;
	} state_t;

	state_t state;
	state_t next_state;
	logic req;
	logic hit;
	logic [2:0] idx;
	logic [31:0] old_word;
	logic [31:0] merged_word;

	// ************************************************************
	// Decode
	// ************************************************************
	always_comb begin
		req = wb_cyc_i & wb_stb_i;
		hit = addr_hit(wb_adr_i);
		idx = addr_index(wb_adr_i);
		old_word = hit ? state.regs[idx] : RESET_VALUE;
	end

	remap_word_merge u_merge (
		.old_word(old_word),
		.wr_data(wb_dat_i),
		.wr_sel(wb_sel_i),
		.wr_mask(wmask_of(idx)),
		.merged_word(merged_word)
	);

	// ************************************************************
	// Next state
	// ************************************************************
	always_comb begin
		next_state = state;
		// Ack one cycle after the request, dropped the cycle after
		next_state.ack = req & ~state.ack;
		if (req & ~state.ack) begin
			next_state.rdata = old_word;
		end
		// Write lands at the edge where the master samples ack
		if (req & wb_we_i & state.ack & hit) begin
			next_state.regs[idx] = merged_word;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************
	assign wb_ack_o = state.ack;
	assign wb_dat_o = state.rdata;
	assign sec_nonpref_lower_base =
		state.regs[IDX_SEC_NONPREF_CTRL][LOWER_BASE_MSB:LOWER_BASE_LSB];
	assign io_discard_bits =
		state.regs[IDX_SEC_NONPREF_CTRL][IO_DISCARD_MSB:IO_DISCARD_LSB];
	assign nonpref_remap_enable = state.regs[IDX_SEC_NONPREF_CTRL][REMAP_ENABLE_BIT];
	assign sec_nonpref_upper_base = state.regs[IDX_SEC_NONPREF_UPPER_BASE];
	assign sec_pref_lower_base =
		state.regs[IDX_SEC_PREF_CTRL][LOWER_BASE_MSB:LOWER_BASE_LSB];
	assign pref_remap_enable = state.regs[IDX_SEC_PREF_CTRL][REMAP_ENABLE_BIT];
	assign sec_pref_upper_base = state.regs[IDX_SEC_PREF_UPPER_BASE];
	assign pri_nonpref_upper_base = state.regs[IDX_PRI_NONPREF_UPPER_BASE];
	assign pri_nonpref_upper_limit = state.regs[IDX_PRI_NONPREF_UPPER_LIMIT];

	// ************************************************************
	// Assertions
	// ************************************************************
	logic full_wr;
	logic wr_land;
	logic rd_take;
	assign full_wr = req & wb_we_i & state.ack & (wb_sel_i == 4'hF);
	assign wr_land = req & wb_we_i & state.ack & hit;
	assign rd_take = req & ~wb_we_i & ~state.ack;

	a_np_lower_base: assert property (@(posedge clk) disable iff (!arst_n)
		full_wr && wb_adr_i == OFF_SEC_NONPREF_CTRL
		|=> sec_nonpref_lower_base == $past(wb_dat_i[31:20]))
		else $error("np lower base not written");

	a_io_discard: assert property (@(posedge clk) disable iff (!arst_n)
		full_wr && wb_adr_i == OFF_SEC_NONPREF_CTRL
		|=> io_discard_bits == $past(wb_dat_i[12:8]))
		else $error("io discard count not written");

	a_np_enable: assert property (@(posedge clk) disable iff (!arst_n)
		full_wr && wb_adr_i == OFF_SEC_NONPREF_CTRL
		|=> nonpref_remap_enable == $past(wb_dat_i[3]))
		else $error("np enable not written");

	a_pref_lower_base: assert property (@(posedge clk) disable iff (!arst_n)
		full_wr && wb_adr_i == OFF_SEC_PREF_CTRL
		|=> sec_pref_lower_base == $past(wb_dat_i[31:20]))
		else $error("pref lower base not written");

	a_pref_enable: assert property (@(posedge clk) disable iff (!arst_n)
		full_wr && wb_adr_i == OFF_SEC_PREF_CTRL
		|=> pref_remap_enable == $past(wb_dat_i[3]))
		else $error("pref enable not written");

	a_sec_upper_bases: assert property (@(posedge clk) disable iff (!arst_n)
		full_wr && (wb_adr_i == OFF_SEC_NONPREF_UPPER_BASE || wb_adr_i == OFF_SEC_PREF_UPPER_BASE)
		|=> (($past(wb_adr_i) == OFF_SEC_NONPREF_UPPER_BASE) ?
		(sec_nonpref_upper_base == $past(wb_dat_i)) :
		(sec_pref_upper_base == $past(wb_dat_i))))
		else $error("secondary upper base not written");

	a_pri_upper_base: assert property (@(posedge clk) disable iff (!arst_n)
		full_wr && wb_adr_i == OFF_PRI_NONPREF_UPPER_BASE
		|=> pri_nonpref_upper_base == $past(wb_dat_i))
		else $error("primary upper base not written");

	a_pri_upper_limit: assert property (@(posedge clk) disable iff (!arst_n)
		full_wr && wb_adr_i == OFF_PRI_NONPREF_UPPER_LIMIT
		|=> pri_nonpref_upper_limit == $past(wb_dat_i))
		else $error("primary upper limit not written");

	a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
		req && !wb_we_i && !state.ack &&
		(wb_adr_i == OFF_SEC_NONPREF_CTRL || wb_adr_i == OFF_SEC_PREF_CTRL)
		|=> (wb_dat_o & ~(($past(wb_adr_i) == OFF_SEC_PREF_CTRL) ?
		WMASK_PREF_CTRL : WMASK_NONPREF_CTRL)) == 32'h0000_0000)
		else $error("reserved control bits read nonzero");

	a_hold_no_write: assert property (@(posedge clk) disable iff (!arst_n)
		!(req && wb_we_i && state.ack)
		|=> $stable(pri_nonpref_upper_limit) && $stable(sec_nonpref_upper_base)
		&& $stable(nonpref_remap_enable) && $stable(pref_remap_enable)
		&& $stable(sec_nonpref_lower_base) && $stable(io_discard_bits)
		&& $stable(sec_pref_lower_base) && $stable(sec_pref_upper_base)
		&& $stable(pri_nonpref_upper_base))
		else $error("field changed without a write");

	a_ack_pulse: assert property (@(posedge clk) disable iff (!arst_n)
		req && !state.ack |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a one cycle answer");

	a_ack_needs_req: assert property (@(posedge clk) disable iff (!arst_n)
		!req |=> !wb_ack_o)
		else $error("ack without a request");

	a_unmapped_read: assert property (@(posedge clk) disable iff (!arst_n)
		rd_take && !hit |=> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");

	// ************************************************************
	// Reset values
	// ************************************************************
	a_rst_np_lower: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(arst_n) |-> sec_nonpref_lower_base == 12'h000)
		else $error("np lower base not zero after reset");

	a_rst_io_discard: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(arst_n) |-> io_discard_bits == 5'h00)
		else $error("io discard count not zero after reset");

	a_rst_np_enable: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(arst_n) |-> nonpref_remap_enable == 1'h0)
		else $error("np enable not zero after reset");

	a_rst_pref_lower: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(arst_n) |-> sec_pref_lower_base == 12'h000)
		else $error("pref lower base not zero after reset");

	a_rst_pref_enable: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(arst_n) |-> pref_remap_enable == 1'h0)
		else $error("pref enable not zero after reset");

	a_rst_sec_upper: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(arst_n) |-> sec_nonpref_upper_base == RESET_VALUE && sec_pref_upper_base == RESET_VALUE)
		else $error("secondary upper base not zero after reset");

	a_rst_pri_upper: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(arst_n) |-> pri_nonpref_upper_base == RESET_VALUE)
		else $error("primary upper base not zero after reset");

	a_rst_pri_limit: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(arst_n) |-> pri_nonpref_upper_limit == RESET_VALUE)
		else $error("primary upper limit not zero after reset");

	a_rst_bus_idle: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(arst_n) |-> !wb_ack_o && wb_dat_o == 32'h0000_0000)
		else $error("bus outputs not idle after reset");

	// ************************************************************
	// Write isolation
	// ************************************************************
	a_keep_np_ctrl: assert property (@(posedge clk) disable iff (!arst_n)
		!(wr_land && wb_adr_i[7:2] == OFF_SEC_NONPREF_CTRL[7:2])
		|=> $stable(sec_nonpref_lower_base) && $stable(io_discard_bits)
		&& $stable(nonpref_remap_enable))
		else $error("np control changed without its write");

	a_keep_pref_ctrl: assert property (@(posedge clk) disable iff (!arst_n)
		!(wr_land && wb_adr_i[7:2] == OFF_SEC_PREF_CTRL[7:2])
		|=> $stable(sec_pref_lower_base) && $stable(pref_remap_enable))
		else $error("pref control changed without its write");

	a_keep_np_upper: assert property (@(posedge clk) disable iff (!arst_n)
		!(wr_land && wb_adr_i[7:2] == OFF_SEC_NONPREF_UPPER_BASE[7:2])
		|=> $stable(sec_nonpref_upper_base))
		else $error("np upper base changed without its write");

	a_keep_pref_upper: assert property (@(posedge clk) disable iff (!arst_n)
		!(wr_land && wb_adr_i[7:2] == OFF_SEC_PREF_UPPER_BASE[7:2])
		|=> $stable(sec_pref_upper_base))
		else $error("pref upper base changed without its write");

	a_keep_pri_upper: assert property (@(posedge clk) disable iff (!arst_n)
		!(wr_land && wb_adr_i[7:2] == OFF_PRI_NONPREF_UPPER_BASE[7:2])
		|=> $stable(pri_nonpref_upper_base))
		else $error("primary upper base changed without its write");

	a_keep_pri_limit: assert property (@(posedge clk) disable iff (!arst_n)
		!(wr_land && wb_adr_i[7:2] == OFF_PRI_NONPREF_UPPER_LIMIT[7:2])
		|=> $stable(pri_nonpref_upper_limit))
		else $error("primary upper limit changed without its write");

	a_lane_np_upper1: assert property (@(posedge clk) disable iff (!arst_n)
		wr_land && wb_adr_i[7:2] == OFF_SEC_NONPREF_UPPER_BASE[7:2] && !wb_sel_i[1]
		|=> $stable(sec_nonpref_upper_base[15:8]))
		else $error("np upper base lane 1 changed unselected");

	a_lane_np_upper3: assert property (@(posedge clk) disable iff (!arst_n)
		wr_land && wb_adr_i[7:2] == OFF_SEC_NONPREF_UPPER_BASE[7:2] && !wb_sel_i[3]
		|=> $stable(sec_nonpref_upper_base[31:24]))
		else $error("np upper base lane 3 changed unselected");

	a_lane_np_base: assert property (@(posedge clk) disable iff (!arst_n)
		wr_land && wb_adr_i[7:2] == OFF_SEC_NONPREF_CTRL[7:2] && !wb_sel_i[3]
		|=> $stable(sec_nonpref_lower_base[11:4]))
		else $error("np lower base changed by an unselected lane");

	a_lane_np_io: assert property (@(posedge clk) disable iff (!arst_n)
		wr_land && wb_adr_i[7:2] == OFF_SEC_NONPREF_CTRL[7:2] && !wb_sel_i[1]
		|=> $stable(io_discard_bits))
		else $error("io discard count changed by an unselected lane");

	a_lane_np_enable: assert property (@(posedge clk) disable iff (!arst_n)
		wr_land && wb_adr_i[7:2] == OFF_SEC_NONPREF_CTRL[7:2] && !wb_sel_i[0]
		|=> $stable(nonpref_remap_enable))
		else $error("np enable changed by an unselected lane");

	a_lane_pref_base: assert property (@(posedge clk) disable iff (!arst_n)
		wr_land && wb_adr_i[7:2] == OFF_SEC_PREF_CTRL[7:2] && !wb_sel_i[3]
		|=> $stable(sec_pref_lower_base[11:4]))
		else $error("pref lower base changed by an unselected lane");

	// ************************************************************
	// Read path
	// ************************************************************
	a_read_np_ctrl: assert property (@(posedge clk) disable iff (!arst_n)
		rd_take && wb_adr_i[7:2] == OFF_SEC_NONPREF_CTRL[7:2]
		|=> wb_dat_o[31:20] == $past(sec_nonpref_lower_base)
		&& wb_dat_o[12:8] == $past(io_discard_bits)
		&& wb_dat_o[3] == $past(nonpref_remap_enable))
		else $error("np control read wrong");

	a_read_pref_ctrl: assert property (@(posedge clk) disable iff (!arst_n)
		rd_take && wb_adr_i[7:2] == OFF_SEC_PREF_CTRL[7:2]
		|=> wb_dat_o[31:20] == $past(sec_pref_lower_base)
		&& wb_dat_o[3] == $past(pref_remap_enable))
		else $error("pref control read wrong");

	a_read_np_upper: assert property (@(posedge clk) disable iff (!arst_n)
		rd_take && wb_adr_i[7:2] == OFF_SEC_NONPREF_UPPER_BASE[7:2]
		|=> wb_dat_o == $past(sec_nonpref_upper_base))
		else $error("np upper base read wrong");

	a_read_pref_upper: assert property (@(posedge clk) disable iff (!arst_n)
		rd_take && wb_adr_i[7:2] == OFF_SEC_PREF_UPPER_BASE[7:2]
		|=> wb_dat_o == $past(sec_pref_upper_base))
		else $error("pref upper base read wrong");

	a_read_pri_upper: assert property (@(posedge clk) disable iff (!arst_n)
		rd_take && wb_adr_i[7:2] == OFF_PRI_NONPREF_UPPER_BASE[7:2]
		|=> wb_dat_o == $past(pri_nonpref_upper_base))
		else $error("primary upper base read wrong");

	a_read_pri_limit: assert property (@(posedge clk) disable iff (!arst_n)
		rd_take && wb_adr_i[7:2] == OFF_PRI_NONPREF_UPPER_LIMIT[7:2]
		|=> wb_dat_o == $past(pri_nonpref_upper_limit))
		else $error("primary upper limit read wrong");

	// ************************************************************
	// Reserved bits
	// ************************************************************
	a_rsv_np_ctrl: assert property (@(posedge clk) disable iff (!arst_n)
		(state.regs[IDX_SEC_NONPREF_CTRL] & ~WMASK_NONPREF_CTRL) == 32'h0000_0000)
		else $error("np control reserved bits set");

	a_rsv_pref_ctrl: assert property (@(posedge clk) disable iff (!arst_n)
		(state.regs[IDX_SEC_PREF_CTRL] & ~WMASK_PREF_CTRL) == 32'h0000_0000)
		else $error("pref control reserved bits set");

endmodule

// [core/remap_regs_pkg.sv]
/*
 * Register map, field layout and reset values of the downstream address
 * remap register bank, plus the address decode shared by the bank.
 * Assumes a byte address of 8 bits on a 32-bit classic Wishbone bus.
 */
package remap_regs_pkg;

	// ************************************************************
	// Register offsets
	// ************************************************************
	localparam int NREG = 6;
	localparam logic [7:0] OFF_SEC_NONPREF_CTRL = 8'hE4;
	localparam logic [7:0] OFF_SEC_NONPREF_UPPER_BASE = 8'hE8;
	localparam logic [7:0] OFF_SEC_PREF_CTRL = 8'hEC;
	localparam logic [7:0] OFF_SEC_PREF_UPPER_BASE = 8'hF0;
	localparam logic [7:0] OFF_PRI_NONPREF_UPPER_BASE = 8'hF4;
	localparam logic [7:0] OFF_PRI_NONPREF_UPPER_LIMIT = 8'hF8;

	// ************************************************************
	// Register indices
	// ************************************************************
	localparam logic [2:0] IDX_SEC_NONPREF_CTRL = 3'h0;
	localparam logic [2:0] IDX_SEC_NONPREF_UPPER_BASE = 3'h1;
	localparam logic [2:0] IDX_SEC_PREF_CTRL = 3'h2;
	localparam logic [2:0] IDX_SEC_PREF_UPPER_BASE = 3'h3;
	localparam logic [2:0] IDX_PRI_NONPREF_UPPER_BASE = 3'h4;
	localparam logic [2:0] IDX_PRI_NONPREF_UPPER_LIMIT = 3'h5;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int LOWER_BASE_LSB = 20;
	localparam int LOWER_BASE_MSB = 31;
	localparam int IO_DISCARD_LSB = 8;
	localparam int IO_DISCARD_MSB = 12;
	localparam int REMAP_ENABLE_BIT = 3;

	// ************************************************************
	// Writable masks and reset values
	// ************************************************************
	localparam logic [31:0] WMASK_NONPREF_CTRL = 32'hFFF0_1F08;
	localparam logic [31:0] WMASK_PREF_CTRL = 32'hFFF0_0008;
	localparam logic [31:0] WMASK_FULL = 32'hFFFF_FFFF;
	localparam logic [31:0] RESET_VALUE = 32'h0000_0000;

	// ************************************************************
	// Address decode
	// ************************************************************
	function automatic logic addr_hit(input logic [7:0] addr);
		logic [5:0] w;
		w = addr[7:2];
		addr_hit = (w >= OFF_SEC_NONPREF_CTRL[7:2]) && (w <= OFF_PRI_NONPREF_UPPER_LIMIT[7:2]);
	endfunction

	function automatic logic [2:0] addr_index(input logic [7:0] addr);
		logic [5:0] d;
		d = addr[7:2] - OFF_SEC_NONPREF_CTRL[7:2];
		addr_index = d[2:0];
	endfunction

	function automatic logic [31:0] wmask_of(input logic [2:0] idx);
		case (idx)
			IDX_SEC_NONPREF_CTRL: wmask_of = WMASK_NONPREF_CTRL;
			IDX_SEC_PREF_CTRL: wmask_of = WMASK_PREF_CTRL;
			default: wmask_of = WMASK_FULL;
		endcase
	endfunction

endpackage

// [core/remap_word_merge.sv]
/*
 * Byte-lane write merge for one register word: the new value keeps the old
 * bits outside the selected lanes and outside the writable mask.
 * Assumes purely combinational use by the register bank.
 */
`timescale 1ns/1ns
module remap_word_merge (
	// Old word and write request
	input wire logic [31:0] old_word,
	input wire logic [31:0] wr_data,
	input wire logic [3:0] wr_sel,
	input wire logic [31:0] wr_mask,
	// Merged word
	output logic [31:0] merged_word
);
	logic [31:0] lane_mask;

	always_comb begin
		lane_mask = {{8{wr_sel[3]}}, {8{wr_sel[2]}}, {8{wr_sel[1]}}, {8{wr_sel[0]}}};
		merged_word = (old_word & ~(lane_mask & wr_mask)) | (wr_data & lane_mask & wr_mask);
	end

endmodule

// [test/downstream_addr_remap_regs_bench.sv]
/*
 * Self-checking bench for the downstream address remap register bank.
 * Assumes the bank answers each classic Wishbone request with one ack.
 */
`timescale 1ns/1ns
module downstream_addr_remap_regs_bench;
	import remap_regs_pkg::*;

	// ************************************************************
	// Signals and design
	// ************************************************************
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0000_0000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [11:0] sec_nonpref_lower_base;
	logic [4:0] io_discard_bits;
	logic nonpref_remap_enable;
	logic [31:0] sec_nonpref_upper_base;
	logic [11:0] sec_pref_lower_base;
	logic pref_remap_enable;
	logic [31:0] sec_pref_upper_base;
	logic [31:0] pri_nonpref_upper_base;
	logic [31:0] pri_nonpref_upper_limit;
	logic [31:0] out_w [6];
	logic [31:0] mask_w [6] = '{32'hFFF0_1F08, 32'hFFFF_FFFF, 32'hFFF0_0008,
		32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hFFFF_FFFF};
	logic [31:0] rd;
	int bad_count = 0;
	int n_tests = 0;

	always #5 clk = ~clk;

	downstream_addr_remap_regs uut (.clk(clk), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.sec_nonpref_lower_base(sec_nonpref_lower_base), .io_discard_bits(io_discard_bits),
		.nonpref_remap_enable(nonpref_remap_enable),
		.sec_nonpref_upper_base(sec_nonpref_upper_base),
		.sec_pref_lower_base(sec_pref_lower_base), .pref_remap_enable(pref_remap_enable),
		.sec_pref_upper_base(sec_pref_upper_base),
		.pri_nonpref_upper_base(pri_nonpref_upper_base),
		.pri_nonpref_upper_limit(pri_nonpref_upper_limit));

	// Field outputs packed back into register words
	assign out_w[0] = {sec_nonpref_lower_base, 7'h00, io_discard_bits, 4'h0,
		nonpref_remap_enable, 3'h0};
	assign out_w[1] = sec_nonpref_upper_base;
	assign out_w[2] = {sec_pref_lower_base, 16'h0000, pref_remap_enable, 3'h0};
	assign out_w[3] = sec_pref_upper_base;
	assign out_w[4] = pri_nonpref_upper_base;
	assign out_w[5] = pri_nonpref_upper_limit;

	// ************************************************************
	// Tasks
	// ************************************************************
	task automatic end_of_test();
		if (bad_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wb_cycle(input logic we, input logic [7:0] a, input logic [3:0] s,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_sel_i <= s;
		wb_dat_i <= d;
		do begin
			@(posedge clk);
			n++;
			if (n > 20) begin
				bad_count++;
				$display("[ERR] ack expected 1 seen 0");
				end_of_test();
			end
		end while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
		logic [31:0] q;
		wb_cycle(1'b1, a, s, d, q);
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wb_cycle(1'b0, a, 4'hF, 32'h0000_0000, q);
		chk32("read data", exp, q);
	endtask

	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			chk32("field reset", 32'h0000_0000, out_w[i]);
			rd_chk(8'hE4 + 8'(4 * i), 32'h0000_0000);
		end
		for (int i = 0; i < 6; i++) begin
			wr(8'hE4 + 8'(4 * i), 4'hF, 32'hFFFF_FFFF);
			@(negedge clk);
			chk32("field after write", mask_w[i], out_w[i]);
			rd_chk(8'hE4 + 8'(4 * i), mask_w[i]);
		end
		wr(8'hE4, 4'h2, 32'h0000_0000);
		rd_chk(8'hE4, 32'hFFF0_0008);
		wr(8'hE4, 4'h1, 32'h0000_0000);
		@(negedge clk);
		chk32("np enable", 32'hFFF0_0000, out_w[0]);
		wr(8'hEC, 4'h1, 32'h0000_0000);
		@(negedge clk);
		chk32("pref enable", 32'hFFF0_0000, out_w[2]);
		wr(8'hE8, 4'h5, 32'h1234_5678);
		rd_chk(8'hE8, 32'hFF34_FF78);
		wr(8'hF8, 4'hF, 32'hA5C3_0F96);
		rd_chk(8'hF8, 32'hA5C3_0F96);
		wr(8'hFC, 4'hF, 32'hFFFF_FFFF);
		rd_chk(8'hFC, 32'h0000_0000);
		rd_chk(8'hE0, 32'h0000_0000);
		rd_chk(8'hF4, 32'hFFFF_FFFF);
		@(posedge clk);
		arst_n <= 1'b0;
		@(negedge clk);
		chk32("field reset", 32'h0000_0000, out_w[5]);
		chk32("field reset", 32'h0000_0000, out_w[0]);
		@(posedge clk);
		arst_n <= 1'b1;
		rd_chk(8'hF4, 32'h0000_0000);
		rd_chk(8'hE4, 32'h0000_0000);
		end_of_test();
	end
endmodule
